// >>> common/uifm_pkg.sv
/*
 * Constants for the universal input fault monitor: time base, field widths,
 * power-on setpoint values and the fault-report state encoding.
 * Assumes a single 100 MHz clock.
 */
package uifm_pkg;

  // ********************************
  // Time base
  // ********************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = (TICK_MS * 1000000) / CLK_PERIOD_NS;

  // ********************************
  // Field widths
  // ********************************
  localparam int unsigned DLY_W = 27;   // Up to 84,600,000 ms
  localparam int unsigned DEB_W = 16;   // Up to 60,000 ms
  localparam int unsigned CNT_W = 17;   // Up to 100,000
  localparam int unsigned PPR_W = 16;   // Up to 65,000
  localparam int unsigned HYS_W = 10;   // Up to 1,000
  localparam int unsigned SPN_W = 19;   // Up to 524,287
  localparam int unsigned FMI_W = 5;
  localparam int unsigned LAMP_W = 2;
  localparam int unsigned REV_W = 32;

  // ********************************
  // Power-on setpoint values, to be driven on the config ports
  // ********************************
  localparam logic [DEB_W-1:0] DEF_DEBOUNCE_MS = 16'h00FA;
  localparam logic [DLY_W-1:0] DEF_SEND_MS = 27'h00003E8;
  localparam logic [DLY_W-1:0] DEF_CLEAR_MS = 27'h0000000;
  localparam logic [HYS_W-1:0] DEF_HYST = 10'h000;
  localparam logic [SPN_W-1:0] DEF_SPN = 19'h00000;
  localparam logic [FMI_W-1:0] FMI_COND_EXISTS = 5'h1F;
  localparam logic [LAMP_W-1:0] LAMP_PROTECT = 2'h0;
  localparam logic [LAMP_W-1:0] LAMP_AMBER = 2'h1;
  localparam logic [LAMP_W-1:0] LAMP_RED = 2'h2;
  localparam logic [LAMP_W-1:0] LAMP_MIL = 2'h3;
  localparam logic [CNT_W-1:0] DEF_PCNT_RESET = 17'h003E8;
  localparam logic [CNT_W-1:0] DEF_WINDOW_MS = 17'h001F4;
  localparam logic [PPR_W-1:0] DEF_PPR = 16'h0000;

  // ********************************
  // Fault report states
  // ********************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PEND_SEND = 5'h02,
    ST_ACTIVE = 5'h04,
    ST_PEND_CLR = 5'h08,
    ST_WAIT_DM11 = 5'h10
  } uifm_state_t;

endpackage : uifm_pkg

// >>> common/uifm_tmr_if.sv
/*
 * Link between the monitor and one millisecond timer.
 * Assumes both ends share clock and reset.
 */
`timescale 1ns/1ps
interface uifm_tmr_if;
  logic run;
  logic [26:0] limit;
  logic done;
  modport owner (output run, output limit, input done);
  modport timer (input run, input limit, output done);
endinterface : uifm_tmr_if

// >>> sim/tb.sv
/*
 * Self-checking bench for the fault monitor: debounce, report delays,
 * DM11 clearing and pulse counting.
 * Assumes a 10-cycle millisecond in the design under test.
 */
`timescale 1ns/1ps
module tb;
  import uifm_pkg::*;
  localparam int CPM = 10;
  logic clock, rstn, in_raw, cfg_logic_inv, cfg_active_low, cfg_dtc_en, cfg_dm11_only;
  logic [DEB_W-1:0] cfg_debounce_ms;
  logic [CNT_W-1:0] cfg_pcnt_reset, cfg_window_ms, pulse_count, window_pulses;
  logic [PPR_W-1:0] cfg_ppr;
  logic [DLY_W-1:0] cfg_send_ms, cfg_clear_ms;
  logic [HYS_W-1:0] cfg_hyst;
  logic [SPN_W-1:0] cfg_spn, dtc_spn;
  logic [FMI_W-1:0] cfg_fmi, dtc_fmi;
  logic [LAMP_W-1:0] cfg_lamp, dtc_lamp;
  logic dm11_rx, input_state, dtc_active, dm11_req;
  logic [7:0] dm11_lat;
  logic [REV_W-1:0] rev_count, r0;
  int n_mismatch = 0;
  int checked = 0;
  int n;

  uifm_top #(.CYC_PER_MS(CPM)) i_dut (.clock, .rstn, .in_raw, .cfg_logic_inv,
    .cfg_active_low, .cfg_debounce_ms, .cfg_pcnt_reset, .cfg_window_ms, .cfg_ppr,
    .cfg_dtc_en, .cfg_dm11_only, .cfg_send_ms, .cfg_clear_ms, .cfg_hyst, .cfg_spn,
    .cfg_fmi, .cfg_lamp, .dm11_rx, .input_state, .dtc_active, .dtc_spn, .dtc_fmi,
    .dtc_lamp, .pulse_count, .window_pulses, .rev_count);
  uifm_net_node i_node (.clock(clock), .send_req(dm11_req), .lat(dm11_lat),
    .dm11_rx(dm11_rx));

  // ********************************
  // Clock and watchdog
  // ********************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end

  // ********************************
  // Helpers
  // ********************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic in_rng(input string name, input int v, input int lo, input int hi);
    check(name, 32'((v >= lo) && (v <= hi)), 32'h1);
  endtask : in_rng
  // Drive the pin, then wait whole milliseconds
  task automatic hold(input logic v, input int ms);
    @(negedge clock);
    in_raw = v;
    repeat (ms * CPM) @(negedge clock);
  endtask : hold
  // Set the pin and count cycles until input_state or dtc_active shows v
  task automatic wait_sig(input logic v, input bit sel, input logic pin, output int k);
    @(negedge clock);
    in_raw = pin;
    k = 0;
    while (((sel ? dtc_active : input_state) !== v) && (k < 300)) begin
      @(negedge clock);
      k++;
    end
  endtask : wait_sig
  task automatic send_dm11(input logic [7:0] l);
    @(negedge clock);
    dm11_lat = l;
    dm11_req = 1'b1;
    @(negedge clock);
    dm11_req = 1'b0;
  endtask : send_dm11
  task automatic pulses(input int cnt, input int half);
    repeat (cnt) begin
      hold(1'b1, 0);
      repeat (half - 1) @(negedge clock);
      hold(1'b0, 0);
      repeat (half - 1) @(negedge clock);
    end
  endtask : pulses
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // ********************************
  // Tests
  // ********************************
  initial begin
    rstn = 1'b0; in_raw = 1'b0; cfg_logic_inv = 1'b0; cfg_active_low = 1'b0;
    cfg_debounce_ms = 16'h0003; cfg_pcnt_reset = DEF_PCNT_RESET; cfg_window_ms = 17'h00005;
    cfg_ppr = 16'h0002; cfg_dtc_en = 1'b0; cfg_dm11_only = 1'b0; cfg_send_ms = 27'h0000008;
    cfg_clear_ms = 27'h0000003; cfg_hyst = 10'h002; cfg_spn = 19'h7FFFF;
    cfg_fmi = FMI_COND_EXISTS; cfg_lamp = LAMP_AMBER; dm11_req = 1'b0; dm11_lat = 8'h00;
    repeat (3) @(posedge clock);
    @(negedge clock) rstn = 1'b1;
    repeat (5) @(negedge clock);
    check("dtc_reset", dtc_active, 32'h0);
    // Short blip filtered, then a held level passes after 3 ms
    hold(1'b1, 1);
    hold(1'b0, 4);
    check("blip", input_state, 32'h0);
    wait_sig(1'b1, 1'b0, 1'b1, n);
    in_rng("debounce", n, 20, 35);
    hold(1'b1, 12);
    check("dtc_off", dtc_active, 32'h0);
    wait_sig(1'b0, 1'b0, 1'b0, n);
    // Interrupted activity restarts the send delay
    cfg_dtc_en = 1'b1;
    wait_sig(1'b1, 1'b0, 1'b1, n);
    hold(1'b1, 2);
    wait_sig(1'b0, 1'b0, 1'b0, n);
    check("no_early", dtc_active, 32'h0);
    wait_sig(1'b1, 1'b0, 1'b1, n);
    wait_sig(1'b1, 1'b1, 1'b1, n);
    in_rng("send_delay", n, 70, 85);
    check("spn", dtc_spn, 32'h7FFFF);
    check("fmi", dtc_fmi, 32'h1F);
    for (int l = 0; l < 4; l++) begin
      cfg_lamp = LAMP_W'(l);
      repeat (3) @(negedge clock);
      check("lamp", dtc_lamp, 32'(l));
    end
    // Brief inactivity restarts the clear delay
    wait_sig(1'b0, 1'b0, 1'b0, n);
    hold(1'b0, 1);
    wait_sig(1'b1, 1'b0, 1'b1, n);
    check("no_clear", dtc_active, 32'h1);
    wait_sig(1'b0, 1'b0, 1'b0, n);
    wait_sig(1'b0, 1'b1, 1'b0, n);
    in_rng("clear_hyst", n, 40, 55);
    // Clearing by DM11 only, ignored while the input is active
    cfg_dm11_only = 1'b1;
    wait_sig(1'b1, 1'b1, 1'b1, n);
    send_dm11(8'h00);
    repeat (5) @(negedge clock);
    check("dm11_active", dtc_active, 32'h1);
    wait_sig(1'b0, 1'b0, 1'b0, n);
    hold(1'b0, 10);
    check("dm11_wait", dtc_active, 32'h1);
    send_dm11(8'h14);
    wait_sig(1'b0, 1'b1, 1'b0, n);
    in_rng("dm11_clear", n, 19, 30);
    cfg_dm11_only = 1'b0;
    cfg_dtc_en = 1'b0;
    // Pulse counter wrap and revolutions
    cfg_debounce_ms = 16'h0000;
    cfg_pcnt_reset = 17'h00000;
    pulses(1, 2);
    check("pcnt_zero", pulse_count, 32'h0);
    r0 = rev_count;
    cfg_pcnt_reset = 17'h00003;
    pulses(4, 2);
    check("pcnt_wrap", pulse_count, 32'h1);
    check("revs", rev_count - r0, 32'h2);
    // Steady 1 ms pulses over a 5 ms window
    cfg_pcnt_reset = DEF_PCNT_RESET;
    pulses(20, 5);
    in_rng("window", int'(window_pulses), 5, 6);
    // Active-low and inverted logic each flip the sensed level
    cfg_active_low = 1'b1;
    hold(1'b0, 1);
    check("active_low", input_state, 32'h1);
    cfg_logic_inv = 1'b1;
    hold(1'b0, 1);
    check("logic_inv", input_state, 32'h0);
    tally_and_finish();
  end
endmodule : tb

// >>> sim/uifm_net_node.sv
/*
 * Far-side network node: sends a DM11 clear request on demand.
 * Assumes the bench pulses send_req for one cycle; lat sets the reply delay.
 */
`timescale 1ns/1ps
module uifm_net_node (
  // Clock
  input wire logic clock,
  // Bench control
  input wire logic send_req,
  input wire logic [7:0] lat,
  // Diagnostic link
  output logic dm11_rx
);
  int cnt = -1;
  // Count down the reply delay
  always @(posedge clock) begin
    if (send_req) cnt <= lat;
    else if (cnt >= 0) cnt <= cnt - 1;
  end
  // One-cycle DM11 pulse, launched off the falling edge
  always @(negedge clock) dm11_rx <= (cnt == 0);
endmodule : uifm_net_node

// >>> src/uifm_timer.sv
/*
 * Millisecond interval timer: counts ticks while run is high, clears when
 * run drops, flags done once the count reaches the limit.
 * Assumes a one-cycle tick enable and a synchronised active-low reset.
 */
`timescale 1ns/1ps
module uifm_timer
  import uifm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Millisecond enable
  input wire logic tick,
  // Owner side
  uifm_tmr_if.timer t
);

  logic [DLY_W-1:0] cnt_ff;

  // Done as soon as elapsed time meets the limit
  assign t.done = t.run && (cnt_ff >= t.limit);

  // Elapsed millisecond count, restarted whenever run drops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (!t.run) begin
      cnt_ff <= '0;
    end else if (tick && !t.done) begin
      cnt_ff <= DLY_W'(cnt_ff + 1'b1);
    end
  end

  property p_tmr_restart;
    @(posedge clock) disable iff (!rst_n) !t.run |=> (cnt_ff == '0);
  endproperty
  a_tmr_restart: assert property (p_tmr_restart) else $error("timer not restarted");

endmodule : uifm_timer

// >>> src/uifm_top.sv
/*
 * Universal input channel with fault monitoring: polarity, debounce,
 * pulse counting and trouble-code reporting with send/clear delays.
 * Assumes config ports are static or changed rarely, and inputs are
 * synchronous to clock. DM11 receipt arrives as a one-cycle pulse.
 */
`timescale 1ns/1ps
// Operation
// - The debounce time is set in milliseconds, 250 by default.
// - With trouble-code generation off, no fault is ever reported.
// - With DM11-only clearing, a fault clears only on DM11 once the input is inactive.
// - Reporting starts only after the input stays active for the send delay.
// - Reporting stops once the input stays inactive for the clear delay.
// - The code carries a configurable SPN from 0 to 524,287, default 0.
// - The code carries a configurable FMI, default condition exists.
// - An event sets a configurable lamp field, default protect.
// - Clearing adds a configurable hysteresis of 0 to 1000, default 0.
// - The pulse counter wraps after a set number of pulses, default 1000.
// - Pulses are measured over a set time window, default 500.
// - Pulses per revolution, 0 to 65000, turn pulses into revolutions.
module uifm_top
  import uifm_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = TICK_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Input pin and conditioning
  input wire logic in_raw,
  input wire logic cfg_logic_inv,
  input wire logic cfg_active_low,
  input wire logic [DEB_W-1:0] cfg_debounce_ms,
  // Pulse counting
  input wire logic [CNT_W-1:0] cfg_pcnt_reset,
  input wire logic [CNT_W-1:0] cfg_window_ms,
  input wire logic [PPR_W-1:0] cfg_ppr,
  // Fault reporting setup
  input wire logic cfg_dtc_en,
  input wire logic cfg_dm11_only,
  input wire logic [DLY_W-1:0] cfg_send_ms,
  input wire logic [DLY_W-1:0] cfg_clear_ms,
  input wire logic [HYS_W-1:0] cfg_hyst,
  input wire logic [SPN_W-1:0] cfg_spn,
  input wire logic [FMI_W-1:0] cfg_fmi,
  input wire logic [LAMP_W-1:0] cfg_lamp,
  // Diagnostic link
  input wire logic dm11_rx,
  // Status
  output logic input_state,
  output logic dtc_active,
  output logic [SPN_W-1:0] dtc_spn,
  output logic [FMI_W-1:0] dtc_fmi,
  output logic [LAMP_W-1:0] dtc_lamp,
  output logic [CNT_W-1:0] pulse_count,
  output logic [CNT_W-1:0] window_pulses,
  output logic [REV_W-1:0] rev_count
);

  // ********************************
  // Reset release and time base
  // ********************************
  logic rst_s1_ff, rst_s2_ff, rst_n;
  logic [31:0] div_ff;
  logic ms_tick;

  // Two-stage reset release
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rst_n = rst_s2_ff;

  // Millisecond divider
  assign ms_tick = (div_ff == 32'(CYC_PER_MS - 1));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) div_ff <= '0;
    else div_ff <= ms_tick ? '0 : div_ff + 32'h0000_0001;
  end

  // ********************************
  // Conditioning and debounce
  // ********************************
  uifm_tmr_if deb_if ();
  uifm_tmr_if sd_if ();
  uifm_tmr_if win_if ();
  logic lvl_active;
  logic deb_ff;
  logic deb_rise;

  // Logic type and active state both invert the raw level
  assign lvl_active = in_raw ^ cfg_logic_inv ^ cfg_active_low;
  assign deb_if.run = (lvl_active != deb_ff);
  assign deb_if.limit = DLY_W'(cfg_debounce_ms);
  assign deb_rise = deb_if.done && lvl_active;

  uifm_timer u_deb (.clock(clock), .rst_n(rst_n), .tick(ms_tick), .t(deb_if));
  // Debounced level follows once the new level has held long enough
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) deb_ff <= 1'b0;
    else if (deb_if.done) deb_ff <= lvl_active;
  end

  // ********************************
  // Pulse counting
  // ********************************
  logic [CNT_W-1:0] pcnt_ff, win_acc_ff, win_cnt_ff;
  logic [PPR_W-1:0] ppr_acc_ff;
  logic [REV_W-1:0] rev_ff;
  logic win_rst_ff;
  logic pcnt_hit, rev_hit;
  logic [CNT_W-1:0] pcnt_inc, win_inc;
  logic [PPR_W-1:0] ppr_inc;
  assign pcnt_inc = CNT_W'(pcnt_ff + 1'b1);
  assign win_inc = deb_rise ? CNT_W'(win_acc_ff + 1'b1) : win_acc_ff;
  assign ppr_inc = PPR_W'(ppr_acc_ff + 1'b1);
  assign pcnt_hit = deb_rise && (pcnt_inc >= cfg_pcnt_reset);
  assign rev_hit = deb_rise && (cfg_ppr != '0) && (ppr_inc >= cfg_ppr);
  assign win_if.run = !win_rst_ff;
  assign win_if.limit = DLY_W'(cfg_window_ms);

  uifm_timer u_win (.clock(clock), .rst_n(rst_n), .tick(ms_tick), .t(win_if));
  // Running pulse counter with wrap at the reset number
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) pcnt_ff <= '0;
    else if (pcnt_hit) pcnt_ff <= '0;
    else if (deb_rise) pcnt_ff <= pcnt_inc;
  end

  // Pulses per time window, snapshot at window end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      win_rst_ff <= 1'b0;
      win_acc_ff <= '0;
      win_cnt_ff <= '0;
    end else begin
      win_rst_ff <= win_if.done;
      win_acc_ff <= win_if.done ? '0 : win_inc;
      if (win_if.done) win_cnt_ff <= win_inc;
    end
  end

  // Revolutions from pulses per revolution, idle when set to zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ppr_acc_ff <= '0;
      rev_ff <= '0;
    end else if (rev_hit) begin
      ppr_acc_ff <= '0;
      rev_ff <= REV_W'(rev_ff + 1'b1);
    end else if (deb_rise) begin
      ppr_acc_ff <= ppr_inc;
    end
  end

  // ********************************
  // Fault report sequencing
  // ********************************
  uifm_state_t st_ff, nxt_st;
  logic dtc_ff;
  logic [SPN_W-1:0] spn_ff;
  logic [FMI_W-1:0] fmi_ff;
  logic [LAMP_W-1:0] lamp_ff;
  logic in_send, in_clr;
  assign in_send = (st_ff == ST_PEND_SEND);
  assign in_clr = (st_ff == ST_PEND_CLR);
  // Shared timer runs only while the awaited condition holds
  assign sd_if.run = (in_send && deb_ff) || (in_clr && !deb_ff);
  assign sd_if.limit = in_clr ? DLY_W'(cfg_clear_ms + DLY_W'(cfg_hyst))
                              : cfg_send_ms;

  uifm_timer u_sd (.clock(clock), .rst_n(rst_n), .tick(ms_tick), .t(sd_if));
  // Next report state
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: begin
        if (deb_ff) nxt_st = ST_PEND_SEND;
      end
      ST_PEND_SEND: begin
        if (!deb_ff) nxt_st = ST_IDLE;
        else if (sd_if.done) nxt_st = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (!deb_ff) nxt_st = cfg_dm11_only ? ST_WAIT_DM11 : ST_PEND_CLR;
      end
      ST_PEND_CLR: begin
        if (deb_ff) nxt_st = ST_ACTIVE;
        else if (sd_if.done) nxt_st = ST_IDLE;
      end
      ST_WAIT_DM11: begin
        if (deb_ff) nxt_st = ST_ACTIVE;
        else if (dm11_rx) nxt_st = ST_IDLE;
      end
      default: nxt_st = ST_IDLE;
    endcase
    if (!cfg_dtc_en) nxt_st = ST_IDLE;
  end

  // State, report flag and code fields
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_IDLE;
      dtc_ff <= 1'b0;
      spn_ff <= '0;
      fmi_ff <= '0;
      lamp_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      dtc_ff <= (nxt_st == ST_ACTIVE) || (nxt_st == ST_PEND_CLR) || (nxt_st == ST_WAIT_DM11);
      spn_ff <= cfg_spn;
      fmi_ff <= cfg_fmi;
      lamp_ff <= cfg_lamp;
    end
  end

  assign input_state = deb_ff;
  assign dtc_active = dtc_ff;
  assign dtc_spn = spn_ff;
  assign dtc_fmi = fmi_ff;
  assign dtc_lamp = lamp_ff;
  assign pulse_count = pcnt_ff;
  assign window_pulses = win_cnt_ff;
  assign rev_count = rev_ff;

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_deb_hold;
    $changed(deb_ff) |-> $past(deb_if.done) && (deb_ff == $past(lvl_active));
  endproperty
  a_deb_hold: assert property (p_deb_hold) else $error("debounce bypassed");
  property p_no_dtc;
    !cfg_dtc_en |=> !dtc_ff;
  endproperty
  a_no_dtc: assert property (p_no_dtc) else $error("report while disabled");
  property p_dm11_clear;
    $fell(dtc_ff) && $past(cfg_dm11_only && cfg_dtc_en && st_ff != ST_PEND_CLR)
      |-> $past(dm11_rx && !deb_ff);
  endproperty
  a_dm11_clear: assert property (p_dm11_clear) else $error("clear without DM11");
  property p_send_delay;
    $rose(dtc_ff) && $past(st_ff == ST_PEND_SEND) |-> $past(sd_if.done && deb_ff);
  endproperty
  a_send_delay: assert property (p_send_delay) else $error("early report");
  property p_clear_delay;
    $fell(dtc_ff) && $past(cfg_dtc_en && st_ff == ST_PEND_CLR) |-> $past(sd_if.done);
  endproperty
  a_clear_delay: assert property (p_clear_delay) else $error("early clear");
  property p_fields;
    $past(rst_n) |-> (dtc_spn == $past(cfg_spn)) && (dtc_fmi == $past(cfg_fmi));
  endproperty
  a_fields: assert property (p_fields) else $error("code fields wrong");
  property p_lamp;
    $rose(dtc_ff) |-> (dtc_lamp == $past(cfg_lamp));
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp field wrong");
  // Milliseconds of settled inactivity while a clear is pending
  logic [DLY_W-1:0] clr_ms_ff;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) clr_ms_ff <= '0;
    else if (!in_clr || deb_ff) clr_ms_ff <= '0;
    else if (ms_tick) clr_ms_ff <= DLY_W'(clr_ms_ff + 1'b1);
  end
  property p_hyst;
    in_clr && cfg_dtc_en && (clr_ms_ff < DLY_W'(cfg_clear_ms + DLY_W'(cfg_hyst))) |=> dtc_ff;
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis missing");
  property p_pcnt_wrap;
    pcnt_hit |=> (pcnt_ff == '0) && (pulse_count == '0);
  endproperty
  a_pcnt_wrap: assert property (p_pcnt_wrap) else $error("counter did not wrap");
  property p_window;
    win_if.done |=> (win_acc_ff == '0) ##1 !win_if.done;
  endproperty
  a_window: assert property (p_window) else $error("window not restarted");
  property p_restart;
    (in_send && !deb_ff && cfg_dtc_en) |=> (st_ff == ST_IDLE) && !dtc_ff;
  endproperty
  a_restart: assert property (p_restart) else $error("send timer not restarted");

  c_report: cover property ($rose(dtc_ff));
  c_clear: cover property ($fell(dtc_ff) && $past(st_ff == ST_PEND_CLR));
  c_dm11: cover property ($fell(dtc_ff) && $past(st_ff == ST_WAIT_DM11));
  c_rev: cover property (rev_hit);

endmodule : uifm_top
